/* cecbt_engine_model.sv */
`timescale 1ns/1ns
// stands in for the error counting engine that feeds the count inputs
module cecbt_engine_model (
  input wire logic clk, // module clock
  input wire logic rstn, // reset, active low
  input wire logic load, // take new counts
  input wire logic [7:0] tx_in, // next transmit count
  input wire logic [7:0] rx_in, // next receive count
  output logic [7:0] tx_cnt, // transmit error count
  output logic [7:0] rx_cnt // receive error count
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
    end else if (load) begin
      tx_cnt <= tx_in;
      rx_cnt <= rx_in;
    end
  end
endmodule : cecbt_engine_model

/* cecbt_pkg.sv */
package cecbt_pkg;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] OFS_ERR_COUNT = 4'h0;
  localparam logic [3:0] OFS_BIT_TIMING_ONE = 4'h1;
  localparam logic [3:0] OFS_EVENT_STATUS = 4'h2;
  localparam logic [3:0] OFS_EVENT_MASK = 4'h3;

  // error count register layout
  localparam int CNT_W = 8;
  localparam int TX_LSB = 8;
  localparam int RX_LSB = 0;
  localparam logic [15:0] ERR_COUNT_RST = 16'h0000;

  // bit timing one layout; bits 15..8 are not implemented
  localparam int SJW_LSB = 6;
  localparam int SJW_W = 2;
  localparam int BRP_LSB = 0;
  localparam int BRP_W = 6;
  localparam int TIMING_W = SJW_W + BRP_W;
  localparam logic [7:0] BIT_TIMING_ONE_RST = 8'h00;
  localparam logic [7:0] UNIMP_READ = 8'h00;

  // quantum = TQ_STEP_CLKS * (prescaler + 1) module clock periods
  localparam int CLK_PERIOD_NS = 50;
  localparam int TQ_STEP_CLKS = 2;
  localparam int GAP_W = 8;

  // event status and mask layout
  localparam int NEV = 3;
  localparam int EV_TX_UP = 0;
  localparam int EV_RX_UP = 1;
  localparam int EV_WARN = 2;
  localparam logic [2:0] EVENT_STATUS_RST = 3'h0;
  localparam logic [2:0] EVENT_MASK_RST = 3'h0;
  localparam logic [7:0] WARN_LEVEL_DEF = 8'h60;

  typedef struct packed {
    logic [SJW_W-1:0] jump;
    logic [BRP_W-1:0] prescale;
  } cecbt_timing_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cecbt_bus_s;

endpackage : cecbt_pkg

/* cecbt_quantum.sv */
`timescale 1ns/1ns
// time quantum generator: one tick every 2*(prescale+1) enabled cycles
module cecbt_quantum #(
  parameter int BRP_W = cecbt_pkg::BRP_W
) (
  input wire logic clk, // module clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic restart, // new setting, restart the count
  input wire logic [BRP_W-1:0] prescale, // prescaler code
  output logic tick // one-cycle quantum pulse
);

  logic [BRP_W:0] cnt;
  logic [BRP_W:0] next_cnt;
  logic next_tick;
  logic [BRP_W:0] limit;

  // 2*(code+1)-1 is the code with a one shifted in below it
  assign limit = {prescale, 1'b1};

  always_comb begin
    next_cnt = cnt;
    next_tick = tick;
    if (ce) begin
      if (restart) begin
        next_cnt = '0;
        next_tick = 1'b0;
      end else if (cnt == limit) begin
        next_cnt = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
        next_tick = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule : cecbt_quantum

/* cecbt_sticky.sv */
`timescale 1ns/1ns
// one sticky event flag; a set in the clearing cycle wins
module cecbt_sticky #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // module clock
  input wire logic rstn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic set, // event pulse
  input wire logic clr, // write-one-to-clear pulse
  output logic q // sticky flag
);

  logic next_q;

  always_comb begin
    next_q = q;
    if (ce) begin
      next_q = set | (q & ~clr);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST_VAL;
    end else begin
      q <= next_q;
    end
  end

endmodule : cecbt_sticky

/* cecbt_top.sv */
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ns
//
// Behaviour
// RULE_01: the 8-bit transmit error counter reads, read-only, in bits 15..8 of the error count register.
// RULE_02: the 8-bit receive error counter reads, read-only, in bits 7..0 of the error count register.
// RULE_03: after power-on reset the error count register and all implemented timing bits are zero.
// RULE_04: bits 15..8 of bit timing one read as zero and writes to them are dropped.
// RULE_05: the 2-bit jump width field in bits 7..6 gives code+1 quanta, so code 11 means four.
// RULE_06: the 6-bit prescaler field in bits 5..0 makes one quantum 2*(code+1) clock periods.
// RULE_07: prescaler code 1 makes one quantum four clock periods.
// RULE_08: prescaler code 0 makes one quantum two clock periods, the shortest.
module cecbt_top #(
  parameter logic [7:0] WARN_LEVEL = cecbt_pkg::WARN_LEVEL_DEF
) (
  input wire logic CLK, // module clock, 20 MHz
  input wire logic RSTN, // async power-on reset, active low
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic [3:0] ADDR, // register address
  input wire logic [15:0] WDATA, // register write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [15:0] RDATA, // read data, cycle after RD
  input wire logic [7:0] TX_ERR_CNT, // transmit error count from engine
  input wire logic [7:0] RX_ERR_CNT, // receive error count from engine
  output logic TQ_TICK, // one pulse per time quantum
  output logic [2:0] JUMP_WIDTH_TQ, // resync jump width in quanta
  output logic IRQ // interrupt, level, active high
);

  cecbt_pkg::cecbt_bus_s bus;
  cecbt_pkg::cecbt_timing_s timing;
  cecbt_pkg::cecbt_timing_s next_timing;
  logic [15:0] err_count;
  logic [15:0] next_err_count;
  logic [cecbt_pkg::NEV-1:0] mask;
  logic [cecbt_pkg::NEV-1:0] next_mask;
  logic [cecbt_pkg::NEV-1:0] status;
  logic [cecbt_pkg::NEV-1:0] ev_set;
  logic [cecbt_pkg::NEV-1:0] ev_clr;
  logic [15:0] next_rdata;
  logic [2:0] next_jump;
  logic next_irq;
  logic timing_wr;
  logic [7:0] tx_held;
  logic [7:0] rx_held;
  logic warn_now;
  logic warn_was;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
  assign tx_held = err_count[cecbt_pkg::TX_LSB +: cecbt_pkg::CNT_W];
  assign rx_held = err_count[cecbt_pkg::RX_LSB +: cecbt_pkg::CNT_W];
  assign timing_wr = CE & bus.wr & (bus.addr == cecbt_pkg::OFS_BIT_TIMING_ONE);

  // error count snapshot, one cycle behind the engine
  always_comb begin
    next_err_count = err_count;
    if (CE) begin
      next_err_count[cecbt_pkg::TX_LSB +: cecbt_pkg::CNT_W] = TX_ERR_CNT; // [RULE_01]
      next_err_count[cecbt_pkg::RX_LSB +: cecbt_pkg::CNT_W] = RX_ERR_CNT; // [RULE_02]
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      err_count <= cecbt_pkg::ERR_COUNT_RST; // [RULE_03]
    end else begin
      err_count <= next_err_count;
    end
  end

  err_snap_a: assert property ( // [RULE_01] [RULE_02]
    @(posedge CLK) disable iff (!RSTN)
    CE |=> err_count == {$past(TX_ERR_CNT), $past(RX_ERR_CNT)})
    else $error("error count snapshot wrong");

  // bit timing one; only the low byte holds state
  always_comb begin
    next_timing = timing;
    if (timing_wr) begin
      next_timing = cecbt_pkg::cecbt_timing_s'(bus.wdata[7:0]); // [RULE_04]
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      timing <= cecbt_pkg::BIT_TIMING_ONE_RST; // [RULE_03]
    end else begin
      timing <= next_timing;
    end
  end

  timing_write_a: assert property ( // [RULE_04]
    @(posedge CLK) disable iff (!RSTN)
    (CE && WR && ADDR == cecbt_pkg::OFS_BIT_TIMING_ONE)
    |=> timing == $past(WDATA[7:0]))
    else $error("timing write not taken from low byte");

  timing_keep_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    !(CE && WR && ADDR == cecbt_pkg::OFS_BIT_TIMING_ONE)
    |=> $stable(timing))
    else $error("timing changed without a write");

  // a write restarts the quantum so no stretched quantum mixes two settings
  cecbt_quantum #(
    .BRP_W(cecbt_pkg::BRP_W)
  ) u_quantum (
    .clk(CLK),
    .rstn(RSTN),
    .ce(CE),
    .restart(timing_wr),
    .prescale(timing.prescale), // [RULE_06] [RULE_07] [RULE_08]
    .tick(TQ_TICK)
  );

  // events: counter rises and crossing of the warning level
  assign warn_now = (TX_ERR_CNT >= WARN_LEVEL) | (RX_ERR_CNT >= WARN_LEVEL);
  assign warn_was = (tx_held >= WARN_LEVEL) | (rx_held >= WARN_LEVEL);

  always_comb begin
    ev_set = '0;
    ev_set[cecbt_pkg::EV_TX_UP] = TX_ERR_CNT > tx_held;
    ev_set[cecbt_pkg::EV_RX_UP] = RX_ERR_CNT > rx_held;
    ev_set[cecbt_pkg::EV_WARN] = warn_now & ~warn_was;
    ev_clr = '0;
    if (bus.wr && bus.addr == cecbt_pkg::OFS_EVENT_STATUS) begin
      ev_clr = bus.wdata[cecbt_pkg::NEV-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < cecbt_pkg::NEV; gi++) begin : g_ev
      cecbt_sticky #(
        .RST_VAL(cecbt_pkg::EVENT_STATUS_RST[gi])
      ) u_flag (
        .clk(CLK),
        .rstn(RSTN),
        .ce(CE),
        .set(ev_set[gi]),
        .clr(ev_clr[gi]),
        .q(status[gi])
      );
    end
  endgenerate

  status_set_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    (CE && ev_set != '0) |=> (status & $past(ev_set)) == $past(ev_set))
    else $error("event not latched in status");

  status_clear_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    (CE && WR && ADDR == cecbt_pkg::OFS_EVENT_STATUS && ev_set == '0)
    |=> (status & $past(WDATA[cecbt_pkg::NEV-1:0])) == '0)
    else $error("status bit not cleared by a one");

  // mask register and outputs
  always_comb begin
    next_mask = mask;
    next_jump = JUMP_WIDTH_TQ;
    next_irq = IRQ;
    if (CE) begin
      if (bus.wr && bus.addr == cecbt_pkg::OFS_EVENT_MASK) begin
        next_mask = bus.wdata[cecbt_pkg::NEV-1:0];
      end
      next_jump = {1'b0, timing.jump} + 3'h1; // [RULE_05]
      next_irq = |(status & mask);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mask <= cecbt_pkg::EVENT_MASK_RST;
      JUMP_WIDTH_TQ <= 3'h1;
      IRQ <= 1'b0;
    end else begin
      mask <= next_mask;
      JUMP_WIDTH_TQ <= next_jump;
      IRQ <= next_irq;
    end
  end

  irq_level_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    CE |=> IRQ == $past(|(status & mask)))
    else $error("interrupt level not status and mask");

  // a low enable must hold every register, outputs included
  enable_freeze_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    !CE |=> ($stable(RDATA) && $stable(TQ_TICK) && $stable(IRQ)
      && $stable(JUMP_WIDTH_TQ) && $stable(timing) && $stable(mask)
      && $stable(status) && $stable(err_count)))
    else $error("state moved with clock enable low");

  // read port; data stand only in the cycle after the strobe
  always_comb begin
    next_rdata = RDATA;
    if (CE) begin
      next_rdata = 16'h0000;
      if (bus.rd) begin
        case (bus.addr)
          cecbt_pkg::OFS_ERR_COUNT: begin
            next_rdata = err_count; // [RULE_01] [RULE_02]
          end
          cecbt_pkg::OFS_BIT_TIMING_ONE: begin
            next_rdata = {cecbt_pkg::UNIMP_READ, timing}; // [RULE_04]
          end
          cecbt_pkg::OFS_EVENT_STATUS: begin
            next_rdata = {13'h0000, status};
          end
          cecbt_pkg::OFS_EVENT_MASK: begin
            next_rdata = {13'h0000, mask};
          end
          default: begin
            next_rdata = 16'h0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 16'h0000;
    end else begin
      RDATA <= next_rdata;
    end
  end

  read_idle_a: assert property (
    @(posedge CLK) disable iff (!RSTN)
    (CE && !RD) |=> RDATA == 16'h0000)
    else $error("read data not zero outside a read");

  // helper state for the checks below: quantum spacing and untouched state
  logic [cecbt_pkg::GAP_W-1:0] gap;
  logic gap_valid;
  logic touched;
  logic [cecbt_pkg::GAP_W-1:0] period;

  assign period = {1'b0, timing.prescale, 1'b0} + 8'h02;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap <= '0;
      gap_valid <= 1'b0;
      touched <= 1'b0;
    end else begin
      if (CE) begin
        gap <= TQ_TICK ? 8'h01 : gap + 8'h01;
        touched <= 1'b1;
      end
      if (timing_wr) begin
        gap_valid <= 1'b0;
      end else if (CE && TQ_TICK) begin
        gap_valid <= 1'b1;
      end
    end
  end

  tx_field_read_a: assert property ( // [RULE_01]
    @(posedge CLK) disable iff (!RSTN)
    CE ##1 (CE && RD && ADDR == cecbt_pkg::OFS_ERR_COUNT)
    |=> RDATA[15:8] == $past(TX_ERR_CNT, 2))
    else $error("transmit count not in upper byte");

  rx_field_read_a: assert property ( // [RULE_02]
    @(posedge CLK) disable iff (!RSTN)
    CE ##1 (CE && RD && ADDR == cecbt_pkg::OFS_ERR_COUNT)
    |=> RDATA[7:0] == $past(RX_ERR_CNT, 2))
    else $error("receive count not in lower byte");

  reset_zero_a: assert property ( // [RULE_03]
    @(posedge CLK) disable iff (!RSTN)
    !touched |-> (err_count == 16'h0000 && timing == 8'h00))
    else $error("registers not zero after reset");

  upper_zero_a: assert property ( // [RULE_04]
    @(posedge CLK) disable iff (!RSTN)
    (CE && RD && ADDR == cecbt_pkg::OFS_BIT_TIMING_ONE)
    |=> (RDATA[15:8] == 8'h00 && RDATA[7:0] == $past(timing)))
    else $error("unimplemented timing bits not zero");

  jump_width_a: assert property ( // [RULE_05]
    @(posedge CLK) disable iff (!RSTN)
    CE |=> JUMP_WIDTH_TQ == {1'b0, $past(timing.jump)} + 3'h1)
    else $error("jump width quanta wrong");

  jump_max_a: assert property ( // [RULE_05]
    @(posedge CLK) disable iff (!RSTN)
    (CE && timing.jump == 2'b11) |=> JUMP_WIDTH_TQ == 3'h4)
    else $error("jump code 11 not four quanta");

  quantum_period_a: assert property ( // [RULE_06]
    @(posedge CLK) disable iff (!RSTN)
    (CE && TQ_TICK && gap_valid) |-> gap == period)
    else $error("quantum length not 2*(code+1)");

  quantum_four_a: assert property ( // [RULE_07]
    @(posedge CLK) disable iff (!RSTN)
    (CE && TQ_TICK && gap_valid && timing.prescale == 6'h01)
    |-> gap == 8'h04)
    else $error("code 1 quantum not four clocks");

  quantum_two_a: assert property ( // [RULE_08]
    @(posedge CLK) disable iff (!RSTN)
    (CE && TQ_TICK && gap_valid && timing.prescale == 6'h00)
    |-> gap == 8'h02)
    else $error("code 0 quantum not two clocks");

  tick_restart_a: assert property ( // [RULE_06]
    @(posedge CLK) disable iff (!RSTN)
    timing_wr |=> !TQ_TICK)
    else $error("quantum tick right after timing write");

endmodule : cecbt_top

/* cecbt_top_tb.sv */
`timescale 1ns/1ns
module cecbt_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic [7:0] tx_cnt;
  logic [7:0] rx_cnt;
  logic tq_tick;
  logic [2:0] jump_width_tq;
  logic irq;
  logic ce = 1'b1;
  logic load = 1'b0;
  logic [7:0] tx_in = 8'h00;
  logic [7:0] rx_in = 8'h00;
  logic [15:0] rv;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  // rows: timing write, expected jump width, expected quantum length
  logic [15:0] row_w [4] = '{16'hff00, 16'h0041, 16'h0082, 16'h00ff};
  logic [2:0] row_j [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  int row_p [4] = '{2, 4, 6, 128};

  cecbt_top DUT (
    .CLK(clk),
    .RSTN(rstn),
    .CE(ce),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr),
    .RD(rd),
    .RDATA(rdata),
    .TX_ERR_CNT(tx_cnt),
    .RX_ERR_CNT(rx_cnt),
    .TQ_TICK(tq_tick),
    .JUMP_WIDTH_TQ(jump_width_tq),
    .IRQ(irq)
  );

  cecbt_engine_model engine (
    .clk(clk),
    .rstn(rstn),
    .load(load),
    .tx_in(tx_in),
    .rx_in(rx_in),
    .tx_cnt(tx_cnt),
    .rx_cnt(rx_cnt)
  );

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error t=%0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // cycles until the next quantum pulse, bounded
  task automatic to_tick(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1;
      c++;
    end while (tq_tick !== 1'b1 && c < 300);
    if (c >= 300) begin
      error_cnt++;
      close_out;
    end
  endtask : to_tick

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(4'h0, rv);
    chk(rv, 16'h0000);
    reg_rd(4'h1, rv);
    chk(rv, 16'h0000);
    chk({13'h0000, jump_width_tq}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      reg_wr(4'h1, row_w[i]);
      reg_rd(4'h1, rv);
      chk(rv, {8'h00, row_w[i][7:0]});
      chk({13'h0000, jump_width_tq}, {13'h0000, row_j[i]});
      to_tick(n);
      to_tick(n);
      chk(16'(n), 16'(row_p[i]));
    end
    reg_wr(4'h1, 16'h0000);
    reg_rd(4'hf, rv);
    chk(rv, 16'h0000);
    // clock enable low: a timing write is ignored
    @(posedge clk);
    ce <= 1'b0;
    reg_wr(4'h1, 16'h00c3);
    @(posedge clk);
    ce <= 1'b1;
    reg_rd(4'h1, rv);
    chk(rv, 16'h0000);
    chk({13'h0000, jump_width_tq}, 16'h0001);
    @(posedge clk);
    load <= 1'b1;
    tx_in <= 8'ha5;
    rx_in <= 8'h3c;
    @(posedge clk);
    load <= 1'b0;
    repeat (3) @(posedge clk);
    // a write must not disturb the read-only counters
    reg_wr(4'h0, 16'hffff);
    reg_rd(4'h0, rv);
    chk(rv, 16'ha53c);
    reg_rd(4'h2, rv);
    chk(rv, 16'h0007);
    chk({15'h0000, irq}, 16'h0000);
    reg_wr(4'h3, 16'h0001);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    reg_rd(4'h3, rv);
    chk(rv, 16'h0001);
    reg_wr(4'h2, 16'h0007);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    reg_rd(4'h2, rv);
    chk(rv, 16'h0000);
    // second reset in mid-run clears the timing register again
    reg_wr(4'h1, 16'h00c5);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    reg_rd(4'h1, rv);
    chk(rv, 16'h0000);
    reg_rd(4'h0, rv);
    chk(rv, 16'h0000);
    chk({13'h0000, jump_width_tq}, 16'h0001);
    close_out;
  end
endmodule : cecbt_top_tb
